// ---- logic/pri_regs.sv ----
// register bank of one peripheral with its two dma channels
// assumes a single-master peripheral bus; answer comes one cycle after the request
//
// What this block does
// - only word transfers; byte or halfword addresses are masked to a word
// - decodes a 16-kbyte window, or 4-kbyte when built as the interrupt controller
// - command register is write-only; ones launch commands, zeros do nothing
// - configuration register is read/write and resets to zero
// - status register is read-only; writes never change it
// - a one written to enable sets that shadow bit only
// - a one written to disable clears that shadow bit, visible on read
// - zero bits in enable or disable writes leave shadow bits unchanged
// - reserved bits read zero; software writes zero to them
// - interrupt is the or of status bits each anded with its mask
// - mask is readable and changes only through enable and disable writes
// - eight dma channels overall, one receive and one transmit per peripheral
// - each channel has a 32-bit pointer and 16-bit count register
// - channel registers sit inside this peripheral's own window
// - end-of-transfer status rises when the programmed amount is moved
`timescale 1ns/10ps
`default_nettype none

module pri_regs #(
  parameter logic [31:0] BASE_ADDR = 32'hFFFC_0000,
  parameter bit IS_INTC = 1'b0,
  parameter int unsigned NUM_CH_HERE = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // peripheral bus
  input wire pri_pkg::pri_bus_req_t bus_req,
  output logic [pri_pkg::DATA_W-1:0] bus_rdata,
  output logic bus_ack,
  // peripheral side
  input wire logic [pri_pkg::HW_STAT_W-1:0] hw_status,
  output logic [pri_pkg::DATA_W-1:0] cmd_pulse,
  output logic [pri_pkg::DATA_W-1:0] mode,
  output logic [pri_pkg::DATA_W-1:0] enable_bits,
  // dma movement
  input wire logic rx_step,
  input wire logic tx_step,
  input wire logic [2:0] item_bytes,
  output logic rx_busy,
  output logic tx_busy,
  output logic [pri_pkg::DATA_W-1:0] rx_ptr,
  output logic [pri_pkg::DATA_W-1:0] tx_ptr,
  // to the vectored_interrupt_controller
  output logic irq
);
  import pri_pkg::*;

  // ------------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------------
  localparam int unsigned WIN = IS_INTC ? WIN_INTC_BYTES : WIN_PERIPH_BYTES;
  localparam logic [31:0] WIN_MASK = ~(WIN - 1);
  localparam int unsigned NUM_PERIPH_DMA = DMA_CHANNELS_TOTAL / 2;

  // refused at elaboration: the status word has end bits for one rx and one tx channel only
  if (NUM_CH_HERE != 2 || NUM_PERIPH_DMA != 4)
  begin : g_bad_channels
    $error("each serial peripheral carries exactly one rx and one tx channel");
  end
  // a misaligned base would make the window decode match nothing or alias a neighbour
  if ((BASE_ADDR & ~WIN_MASK) != ZERO_WORD)
  begin : g_bad_base
    $error("base address must be aligned to the window size");
  end
  // peripheral status levels must fit below the reserved upper half of the status word
  if (ST_HW_LSB + HW_STAT_W > 16)
  begin : g_bad_status
    $error("peripheral status field does not fit the status word");
  end

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] cmd;
    logic [31:0] mode;
    logic [31:0] shadow;
    logic [15:0] imask;
    logic [31:0] rdata;
    logic ack;
    logic irq;
    logic rx_busy;
    logic tx_busy;
    logic [31:0] rx_ptr;
    logic [31:0] tx_ptr;
  } pri_state_t;

  pri_state_t st_q;
  pri_state_t st_d;

  logic hit;
  logic wr;
  logic [11:0] ofs;
  logic [31:0] rx_ptr_w;
  logic [31:0] tx_ptr_w;
  logic [15:0] rx_cnt_w;
  logic [15:0] tx_cnt_w;
  logic rx_busy_w;
  logic tx_busy_w;
  logic [15:0] status;

  // low two address bits are dropped so every access is a word access
  assign ofs = {bus_req.addr[11:2], 2'h0};
  // bits 13:12 of a 16-kbyte window are ignored, so the map aliases inside it
  assign hit = bus_req.req && ((bus_req.addr & WIN_MASK) == BASE_ADDR);
  assign wr = hit && bus_req.we;

  // ------------------------------------------------------------------
  // dma channels, mapped in this window
  // ------------------------------------------------------------------
  pri_dma_chan u_rx (
    .clk(clk),
    .rst_b(rst_b),
    .load_ptr(wr && ofs == OFS_RX_PTR),
    .load_cnt(wr && ofs == OFS_RX_CNT),
    .wdata(bus_req.wdata),
    .step(rx_step),
    .step_bytes(item_bytes),
    .ptr(rx_ptr_w),
    .cnt(rx_cnt_w),
    .busy(rx_busy_w)
  );

  pri_dma_chan u_tx (
    .clk(clk),
    .rst_b(rst_b),
    .load_ptr(wr && ofs == OFS_TX_PTR),
    .load_cnt(wr && ofs == OFS_TX_CNT),
    .wdata(bus_req.wdata),
    .step(tx_step),
    .step_bytes(item_bytes),
    .ptr(tx_ptr_w),
    .cnt(tx_cnt_w),
    .busy(tx_busy_w)
  );

  // end status is a level: it stays up until software loads a new count
  always_comb
  begin
    status = '0;
    status[ST_RX_END] = ~rx_busy_w;
    status[ST_TX_END] = ~tx_busy_w;
    status[ST_HW_LSB +: HW_STAT_W] = hw_status;
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    st_d.cmd = ZERO_WORD;
    st_d.ack = hit;
    st_d.rdata = ZERO_WORD;
    if (wr)
    begin
      case (ofs)
        OFS_CMD: st_d.cmd = bus_req.wdata;
        OFS_MODE: st_d.mode = bus_req.wdata;
        OFS_ENA: st_d.shadow = st_q.shadow | bus_req.wdata;
        OFS_DIS: st_d.shadow = st_q.shadow & ~bus_req.wdata;
        OFS_IEN: st_d.imask = st_q.imask | bus_req.wdata[15:0];
        OFS_IDIS: st_d.imask = st_q.imask & ~bus_req.wdata[15:0];
        // status, shadow and mask read ports ignore writes
        default: st_d.mode = st_q.mode;
      endcase
    end
    else if (hit)
    begin
      case (ofs)
        OFS_MODE: st_d.rdata = st_q.mode;
        OFS_SHADOW: st_d.rdata = st_q.shadow;
        OFS_STATUS: st_d.rdata = {16'h0000, status};
        OFS_IMASK: st_d.rdata = {16'h0000, st_q.imask};
        OFS_RX_PTR: st_d.rdata = rx_ptr_w;
        OFS_RX_CNT: st_d.rdata = {16'h0000, rx_cnt_w};
        OFS_TX_PTR: st_d.rdata = tx_ptr_w;
        OFS_TX_CNT: st_d.rdata = {16'h0000, tx_cnt_w};
        // command register is write-only and reads zero
        default: st_d.rdata = ZERO_WORD;
      endcase
    end
    st_d.irq = |(status & st_q.imask);
    st_d.rx_busy = rx_busy_w;
    st_d.tx_busy = tx_busy_w;
    st_d.rx_ptr = rx_ptr_w;
    st_d.tx_ptr = tx_ptr_w;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q <= '0;
      st_q.mode <= MODE_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------------
  // outputs, all from flops
  // ------------------------------------------------------------------
  assign bus_rdata = st_q.rdata;
  assign bus_ack = st_q.ack;
  assign cmd_pulse = st_q.cmd;
  assign mode = st_q.mode;
  assign enable_bits = st_q.shadow;
  assign irq = st_q.irq;
  assign rx_busy = st_q.rx_busy;
  assign tx_busy = st_q.tx_busy;
  assign rx_ptr = st_q.rx_ptr;
  assign tx_ptr = st_q.tx_ptr;

endmodule

`default_nettype wire

// ---- logic/pri_pkg.sv ----
// package for the peripheral register interface: offsets, widths, bus carrier
// assumes a 32-bit peripheral bus clocked with the block
package pri_pkg;

  // ------------------------------------------------------------------
  // bus and window geometry
  // ------------------------------------------------------------------
  localparam int unsigned DATA_W = 32;
  localparam int unsigned WIN_PERIPH_BYTES = 16384;
  localparam int unsigned WIN_INTC_BYTES = 4096;
  localparam int unsigned DMA_CHANNELS_TOTAL = 8;
  localparam int unsigned DMA_CNT_W = 16;
  localparam int unsigned HW_STAT_W = 8;

  // ------------------------------------------------------------------
  // register offsets (byte addresses inside the window)
  // ------------------------------------------------------------------
  localparam logic [11:0] OFS_CMD = 12'h000;
  localparam logic [11:0] OFS_MODE = 12'h004;
  localparam logic [11:0] OFS_ENA = 12'h008;
  localparam logic [11:0] OFS_DIS = 12'h00C;
  localparam logic [11:0] OFS_SHADOW = 12'h010;
  localparam logic [11:0] OFS_STATUS = 12'h014;
  localparam logic [11:0] OFS_IEN = 12'h018;
  localparam logic [11:0] OFS_IDIS = 12'h01C;
  localparam logic [11:0] OFS_IMASK = 12'h020;
  localparam logic [11:0] OFS_RX_PTR = 12'h030;
  localparam logic [11:0] OFS_RX_CNT = 12'h034;
  localparam logic [11:0] OFS_TX_PTR = 12'h038;
  localparam logic [11:0] OFS_TX_CNT = 12'h03C;

  // ------------------------------------------------------------------
  // status layout and reset values
  // ------------------------------------------------------------------
  localparam int unsigned ST_RX_END = 0;
  localparam int unsigned ST_TX_END = 1;
  localparam int unsigned ST_HW_LSB = 8;
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;

  typedef struct packed {
    logic req;
    logic we;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } pri_bus_req_t;

endpackage

// ---- logic/pri_dma_chan.sv ----
// one peripheral dma channel: address pointer and transfer count
// assumes the owning peripheral raises step only while the channel is busy
`timescale 1ns/10ps
`default_nettype none

module pri_dma_chan (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register writes
  input wire logic load_ptr,
  input wire logic load_cnt,
  input wire logic [pri_pkg::DATA_W-1:0] wdata,
  // data movement
  input wire logic step,
  input wire logic [2:0] step_bytes,
  // state
  output logic [pri_pkg::DATA_W-1:0] ptr,
  output logic [pri_pkg::DMA_CNT_W-1:0] cnt,
  output logic busy
);
  import pri_pkg::*;

  typedef struct packed {
    logic [31:0] ptr;
    logic [15:0] cnt;
  } pri_chan_st_t;

  pri_chan_st_t st_q;
  pri_chan_st_t st_d;

  always_comb
  begin
    st_d = st_q;
    // a software load wins over a step in the same cycle
    if (step && st_q.cnt != CNT_ZERO)
    begin
      st_d.ptr = st_q.ptr + {29'h0, step_bytes};
      st_d.cnt = st_q.cnt - CNT_ONE;
    end
    if (load_ptr)
    begin
      st_d.ptr = wdata;
    end
    if (load_cnt)
    begin
      st_d.cnt = wdata[DMA_CNT_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign ptr = st_q.ptr;
  assign cnt = st_q.cnt;
  assign busy = (st_q.cnt != CNT_ZERO);

endmodule

`default_nettype wire

// ---- bench/pri_regs_chk.sv ----
// checker for the peripheral register bank, bound to every pri_regs
// assumes the bank answers one cycle after it takes a request
`timescale 1ns/10ps
`default_nettype none
module pri_regs_chk
  import pri_pkg::*;
#(
  parameter logic [31:0] BASE_ADDR = 32'hFFFC_0000,
  parameter bit IS_INTC = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // bus
  input wire pri_pkg::pri_bus_req_t bus_req,
  input wire logic [31:0] bus_rdata,
  input wire logic bus_ack,
  // peripheral side
  input wire logic [7:0] hw_status,
  input wire logic [31:0] cmd_pulse,
  input wire logic [31:0] mode,
  input wire logic [31:0] enable_bits
);
  logic hit, wr, rd_st, w_cmd, w_mode, w_ena, w_dis;
  assign hit = bus_req.req && (IS_INTC ? bus_req.addr[31:12] == BASE_ADDR[31:12]
    : bus_req.addr[31:14] == BASE_ADDR[31:14]);
  assign wr = hit && bus_req.we;
  assign rd_st = hit && !bus_req.we && bus_req.addr[11:2] == OFS_STATUS[11:2];
  assign w_cmd = wr && bus_req.addr[11:2] == OFS_CMD[11:2];
  assign w_mode = wr && bus_req.addr[11:2] == OFS_MODE[11:2];
  assign w_ena = wr && bus_req.addr[11:2] == OFS_ENA[11:2];
  assign w_dis = wr && bus_req.addr[11:2] == OFS_DIS[11:2];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_ack_hit: assert property (hit |=> bus_ack)
    else $error("request in window not answered");
  chk_ack_miss: assert property (!hit |=> !bus_ack)
    else $error("answer without request in window");
  chk_mode_write: assert property (w_mode |=> mode == $past(bus_req.wdata))
    else $error("configuration write lost");
  chk_mode_hold: assert property (!w_mode |=> $stable(mode))
    else $error("configuration changed without write");
  chk_cmd_launch: assert property (w_cmd |=> cmd_pulse == $past(bus_req.wdata))
    else $error("command not launched");
  chk_cmd_quiet: assert property (!w_cmd |=> cmd_pulse == ZERO_WORD)
    else $error("command pulse without write");
  chk_ena_set: assert property (w_ena |=>
    enable_bits == ($past(enable_bits) | $past(bus_req.wdata)))
    else $error("enable write wrong");
  chk_dis_clear: assert property (w_dis |=>
    enable_bits == ($past(enable_bits) & ~$past(bus_req.wdata)))
    else $error("disable write wrong");
  chk_shadow_hold: assert property (!(w_ena || w_dis) |=> $stable(enable_bits))
    else $error("shadow changed without write");
  chk_status_read: assert property (rd_st |=> bus_rdata[31:16] == 16'h0000 &&
    bus_rdata[7:2] == 6'h00 && bus_rdata[15:8] == $past(hw_status))
    else $error("status read wrong");
endmodule
bind pri_regs pri_regs_chk #(.BASE_ADDR(BASE_ADDR), .IS_INTC(IS_INTC)) u_pri_regs_chk (
  .clk(clk), .rst_b(rst_b), .bus_req(bus_req), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
  .hw_status(hw_status), .cmd_pulse(cmd_pulse), .mode(mode), .enable_bits(enable_bits));
`default_nettype wire

// ---- bench/pri_cpu_mdl.sv ----
// processor-side bus master model for the register bank
// assumes the bank takes a request at one edge and answers in the next cycle
`timescale 1ns/10ps
`default_nettype none
module pri_cpu_mdl
  import pri_pkg::*;
(
  // clock
  input wire logic clk,
  // bus
  output var pri_pkg::pri_bus_req_t bus_req,
  input wire logic [31:0] bus_rdata,
  input wire logic bus_ack
);
  initial bus_req = '0;
  // request lasts one edge: holding it longer would be taken as a second access
  task automatic xfer(input logic we, input logic [1:0] sz, input logic [31:0] a,
    input logic [31:0] d, output logic [31:0] rd, output logic ack);
    @(posedge clk);
    #1 bus_req = '{1'b1, we, sz, a, d};
    @(posedge clk);
    #1 bus_req.req = 1'b0;
    bus_req.addr = ~a;
    bus_req.wdata = ~d;
    rd = bus_rdata;
    ack = bus_ack;
  endtask
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking bench for the peripheral register bank
// assumes the checker and the bus master model are compiled beforehand
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import pri_pkg::*;
  localparam logic [31:0] B = 32'hFFFC_0000;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  pri_bus_req_t bus_req;
  logic [31:0] bus_rdata, cmd_pulse, mode, enable_bits, rx_ptr, tx_ptr, rd;
  logic bus_ack, rx_busy, tx_busy, irq, ack;
  logic [7:0] hw_status = 8'h5A;
  logic rx_step = 1'b0;
  logic tx_step = 1'b0;
  logic [2:0] item_bytes = 3'h4;
  int err_total = 0;
  int n_tests = 0;
  always #10 clk = ~clk;
  pri_regs u_pri_regs (.clk(clk), .rst_b(rst_b), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .bus_ack(bus_ack), .hw_status(hw_status), .cmd_pulse(cmd_pulse), .mode(mode),
    .enable_bits(enable_bits), .rx_step(rx_step), .tx_step(tx_step),
    .item_bytes(item_bytes), .rx_busy(rx_busy), .tx_busy(tx_busy), .rx_ptr(rx_ptr),
    .tx_ptr(tx_ptr), .irq(irq));
  pri_cpu_mdl u_pri_cpu_mdl (.clk(clk), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .bus_ack(bus_ack));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] ofs, input logic [31:0] d);
    u_pri_cpu_mdl.xfer(1'b1, 2'b10, B | ofs, d, rd, ack);
  endtask
  task automatic rdc(input logic [11:0] ofs, input logic [31:0] exp, input string what);
    u_pri_cpu_mdl.xfer(1'b0, 2'b10, B | ofs, ZERO_WORD, rd, ack);
    check("ack", {31'h0, ack}, 32'h0000_0001);
    check(what, rd, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic step(input logic r, input logic t);
    @(posedge clk);
    #1 rx_step = r;
    tx_step = t;
    @(posedge clk);
    #1 rx_step = 1'b0;
    tx_step = 1'b0;
  endtask
  task automatic t_reset();
    check("mode", mode, MODE_RST);
    check("irq", {31'h0, irq}, ZERO_WORD);
    rdc(OFS_STATUS, 32'h0000_5A03, "status");
    rdc(OFS_IMASK, ZERO_WORD, "mask");
  endtask
  task automatic t_mode_cmd();
    // byte access at an address that is not word aligned must land as a full word
    u_pri_cpu_mdl.xfer(1'b1, 2'b00, B | 32'h0000_0006, 32'h1234_5678, rd, ack);
    rdc(OFS_MODE, 32'h1234_5678, "mode");
    wr(OFS_CMD, 32'h8000_0001);
    check("cmd", cmd_pulse, 32'h8000_0001);
    tick(1);
    check("cmd idle", cmd_pulse, ZERO_WORD);
    rdc(OFS_CMD, ZERO_WORD, "cmd read");
    // reserved status positions are written as zero, defined ones as one
    wr(OFS_STATUS, 32'h0000_FF03);
    rdc(OFS_STATUS, 32'h0000_5A03, "status");
    u_pri_cpu_mdl.xfer(1'b1, 2'b10, B + 32'h0000_4004, ZERO_WORD, rd, ack);
    check("ack", {31'h0, ack}, ZERO_WORD);
    rdc(OFS_MODE, 32'h1234_5678, "mode kept");
  endtask
  task automatic t_shadow();
    wr(OFS_ENA, 32'h0000_00F0);
    check("ena", enable_bits, 32'h0000_00F0);
    wr(OFS_DIS, 32'h0000_0030);
    rdc(OFS_SHADOW, 32'h0000_00C0, "shadow");
    wr(OFS_ENA, ZERO_WORD);
    wr(OFS_DIS, ZERO_WORD);
    check("hold", enable_bits, 32'h0000_00C0);
  endtask
  task automatic t_dma();
    wr(OFS_IEN, 32'h0000_0003);
    rdc(OFS_IMASK, 32'h0000_0003, "mask");
    check("irq on", {31'h0, irq}, 32'h0000_0001);
    wr(OFS_IDIS, 32'h0000_0003);
    tick(2);
    check("irq off", {31'h0, irq}, ZERO_WORD);
    wr(OFS_RX_PTR, 32'h0000_1000);
    wr(OFS_RX_CNT, 32'h0000_0002);
    wr(OFS_TX_PTR, 32'h0000_2000);
    wr(OFS_TX_CNT, 32'h0000_0001);
    wr(OFS_IEN, 32'h0000_0003);
    tick(2);
    check("irq busy", {31'h0, irq}, ZERO_WORD);
    check("rx busy", {31'h0, rx_busy}, 32'h0000_0001);
    step(1'b1, 1'b1);
    item_bytes = 3'h2;
    step(1'b1, 1'b0);
    // a step at count zero must not move the pointer
    step(1'b1, 1'b1);
    tick(3);
    check("rx ptr", rx_ptr, 32'h0000_1006);
    check("tx ptr", tx_ptr, 32'h0000_2004);
    check("tx busy", {31'h0, tx_busy}, ZERO_WORD);
    check("irq end", {31'h0, irq}, 32'h0000_0001);
    rdc(OFS_RX_CNT, ZERO_WORD, "rx cnt");
    rdc(OFS_RX_PTR, 32'h0000_1006, "rx ptr reg");
  endtask
  task automatic t_rerst();
    wr(OFS_MODE, 32'h0000_00A5);
    @(posedge clk);
    #1 rst_b = 1'b0;
    hw_status = 8'hA5;
    tick(2);
    rst_b = 1'b1;
    check("mode rst", mode, MODE_RST);
    check("shadow rst", enable_bits, ZERO_WORD);
    check("irq rst", {31'h0, irq}, ZERO_WORD);
    check("ptr rst", rx_ptr, ZERO_WORD);
    rdc(OFS_STATUS, 32'h0000_A503, "status hw");
  endtask
  task automatic conclude();
    if (err_total == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    #1 rst_b = 1'b1;
    t_reset();
    t_mode_cmd();
    t_shadow();
    t_dma();
    t_rerst();
    conclude();
  end
  initial
  begin
    #200000;
    err_total++;
    conclude();
  end
endmodule
`default_nettype wire
